// *** design/drive_status_pkg.sv ***
package drive_status_pkg;

  // Control methods that pick the compared frequency
  typedef enum logic [1:0] {
    MODE_VF,
    MODE_FLUX,
    MODE_SENSORLESS,
    MODE_VECTOR
  } ctrl_mode_e;

  // Frequencies, speeds and thresholds are in 0.1 Hz steps
  localparam int FREQ_W = 16;
  typedef logic [FREQ_W-1:0] freq_t;

  localparam freq_t REV_SAME_AS_FIRST = 16'h270f; // Setting 9999
  localparam freq_t FIRST_THR_DEF     = 16'h003c; // 6 Hz
  localparam freq_t SECOND_THR_DEF    = 16'h012c; // 30 Hz
  localparam freq_t THIRD_THR_DEF     = 16'h0258; // 60 Hz
  localparam freq_t LOW_THR_DEF       = 16'h000f; // 1.5 Hz
  localparam logic [6:0] TOL_DEF      = 7'h0a;    // 10 percent
  localparam logic [6:0] TOL_MAX      = 7'h64;    // 100 percent
  localparam logic [23:0] PERCENT_FULL = 24'h000064;

  // Eleven fault causes that open the input contactor
  localparam int NUM_CAUSES = 11;

  // Output terminals and their selector codes
  localparam int NUM_TERMS = 7;
  localparam int TERM_IDX_W = 3;
  typedef logic [7:0] sel_t;
  localparam sel_t NEG_OFFSET     = 8'h64; // Negative logic adds 100
  localparam sel_t SEL_FREQ_ONE   = 8'h04;
  localparam sel_t SEL_FREQ_TWO   = 8'h05;
  localparam sel_t SEL_FREQ_THREE = 8'h06;
  localparam sel_t SEL_SPD_ONE    = 8'h29; // 41
  localparam sel_t SEL_SPD_TWO    = 8'h2a; // 42
  localparam sel_t SEL_SPD_THREE  = 8'h2b; // 43
  localparam sel_t SEL_LOW_SPEED  = 8'h22; // 34
  localparam sel_t SEL_SHUTOFF    = 8'h5b; // 91
  localparam sel_t SEL_HELD_TRIP  = 8'h5e; // 94
  localparam sel_t SEL_TRIP       = 8'h5a; // Arbitrary code for the trip output
  localparam sel_t SEL_AT_SPEED   = 8'h5c; // Arbitrary code for the at-speed flag
  localparam sel_t SEL_NONE       = 8'hff; // Arbitrary code for an idle terminal

  // Dedicated terminals after reset
  localparam int TERM_AT_SPEED  = 1;
  localparam int TERM_FREQ_ONE  = 4;
  localparam int TERM_CHANGEOVER = 5;

  // Control update period
  localparam int CLK_PERIOD_NS = 20;
  localparam int UPDATE_NS     = 1000;
  localparam int UPDATE_CYCLES = (UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 6;

  // Stall trip hold time
  localparam int STALL_MS          = 3000;
  localparam int STALL_CYCLES_DEF  = STALL_MS * (1000000 / CLK_PERIOD_NS);
  localparam int STALL_W           = 28;

  // Threshold settings that travel together
  typedef struct packed {
    logic [6:0] tolerance;
    freq_t      firstThr;
    freq_t      reverseFirstThr;
    freq_t      secondThr;
    freq_t      thirdThr;
    freq_t      lowThr;
  } thresholds_s;

  // Status flags that can be routed to terminals
  typedef struct packed {
    logic atSpeed;
    logic freqOne;
    logic freqTwo;
    logic freqThree;
    logic speedOne;
    logic speedTwo;
    logic speedThree;
    logic lowSpeed;
    logic trip;
    logic heldTrip;
    logic shutoff;
  } status_s;

endpackage

// *** design/drive_status_outputs.sv ***
`timescale 1ns/10ps
module drive_status_outputs #(
  parameter int STALL_CYCLES = drive_status_pkg::STALL_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst,
  // Drive state from the control core
  input  wire drive_status_pkg::ctrl_mode_e            ctrlMode,
  input  wire drive_status_pkg::freq_t                 commandFreq,
  input  wire drive_status_pkg::freq_t                 outputFreq,
  input  wire drive_status_pkg::freq_t                 preSlipFreq,
  input  wire drive_status_pkg::freq_t                 estimatedSpeed,
  input  wire drive_status_pkg::freq_t                 feedbackSpeed,
  input  wire logic                                    reverseRun,
  input  wire logic                                    dcBraking,
  input  wire logic                                    preExciting,
  input  wire logic                                    startTuning,
  input  wire logic [15:0]                             outputTorque,
  input  wire logic                                    torqueLimiting,
  // Settings
  input  wire drive_status_pkg::thresholds_s           thresholds,
  input  wire logic [15:0]                             overloadTorqueLevel,
  input  wire logic                                    routeLoad,
  input  wire logic [drive_status_pkg::TERM_IDX_W-1:0] routeIndex,
  input  wire drive_status_pkg::sel_t                  routeCode,
  // Protection events
  input  wire logic                                    tripRequest,
  input  wire logic [drive_status_pkg::NUM_CAUSES-1:0] tripCause,
  input  wire logic                                    faultReset,
  // Status and terminals
  output drive_status_pkg::status_s                    status,
  output logic                                         stallTripFault,
  output logic [drive_status_pkg::NUM_TERMS-1:0]       terminalOut
);

  // Route a flag set through one selector code; unknown codes leave the terminal off
  // Code 255 is the idle selector, so it is kept out of the negative-logic range
  function automatic logic routeBit(input drive_status_pkg::sel_t code, input drive_status_pkg::status_s s);
    drive_status_pkg::sel_t base;
    logic                   neg;
    logic                   known;
    logic                   val;
    neg   = (code >= drive_status_pkg::NEG_OFFSET) && (code != drive_status_pkg::SEL_NONE);
    base  = neg ? code - drive_status_pkg::NEG_OFFSET : code;
    known = 1'b1;
    case (base)
      drive_status_pkg::SEL_FREQ_ONE:   val = s.freqOne;
      drive_status_pkg::SEL_FREQ_TWO:   val = s.freqTwo;
      drive_status_pkg::SEL_FREQ_THREE: val = s.freqThree;
      drive_status_pkg::SEL_SPD_ONE:    val = s.speedOne;
      drive_status_pkg::SEL_SPD_TWO:    val = s.speedTwo;
      drive_status_pkg::SEL_SPD_THREE:  val = s.speedThree;
      drive_status_pkg::SEL_LOW_SPEED:  val = s.lowSpeed;
      drive_status_pkg::SEL_SHUTOFF:    val = s.shutoff;
      drive_status_pkg::SEL_HELD_TRIP:  val = s.heldTrip;
      drive_status_pkg::SEL_TRIP:       val = s.trip;
      drive_status_pkg::SEL_AT_SPEED:   val = s.atSpeed;
      default: begin
        val   = 1'b0;
        known = 1'b0;
      end
    endcase
    return known ? (val ^ neg) : 1'b0;
  endfunction

  // At or above threshold
  // Shared by all six detect comparisons so their boundary stays the same
  function automatic logic atOrAbove(input drive_status_pkg::freq_t f, input drive_status_pkg::freq_t thr);
    return f >= thr;
  endfunction

  // Update tick state
  logic [drive_status_pkg::TICK_W-1:0] tick_reg;
  logic [drive_status_pkg::TICK_W-1:0] tick_next;
  logic                                updateTick;

  // Route selector state
  drive_status_pkg::sel_t route_reg  [drive_status_pkg::NUM_TERMS];
  drive_status_pkg::sel_t route_next [drive_status_pkg::NUM_TERMS];

  // Fault state
  logic tripOut_reg;
  logic tripOut_next;
  logic heldTrip_reg;
  logic heldTrip_next;
  logic shutoff_reg;
  logic shutoff_next;
  logic resetSeen_reg;
  logic resetSeen_next;

  // Stall detector state
  logic [drive_status_pkg::STALL_W-1:0] stall_reg;
  logic [drive_status_pkg::STALL_W-1:0] stall_next;
  logic                                 stallTrip_reg;
  logic                                 stallTrip_next;

  // Comparison and terminal state
  drive_status_pkg::status_s             flags_reg;
  drive_status_pkg::status_s             flags_next;
  logic [drive_status_pkg::NUM_TERMS-1:0] term_reg;
  logic [drive_status_pkg::NUM_TERMS-1:0] term_next;

  // Shared comparison intermediates
  drive_status_pkg::freq_t compFreq;
  drive_status_pkg::freq_t motorSpeed;
  drive_status_pkg::freq_t firstActive;
  drive_status_pkg::freq_t freqDiff;
  logic [23:0]             bandScaled;
  logic [23:0]             diffScaled;
  logic                    inhibit;
  logic                    stallCond;
  logic                    tripAny;

  // Update period divider
  // Limitation: a setting change can take up to one period to show on a flag
  always_comb begin
    updateTick = (tick_reg == drive_status_pkg::TICK_W'(drive_status_pkg::UPDATE_CYCLES - 1));
    tick_next  = updateTick ? '0 : tick_reg + 1'b1;
  end

  // Tick counter starts at zero, so the first update comes one period after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  // Selector load; a write takes effect at the next update
  // Index 7 names no terminal and is ignored rather than wrapping onto another
  always_comb begin
    for (int i = 0; i < drive_status_pkg::NUM_TERMS; i++) begin
      route_next[i] = route_reg[i];
    end
    if (routeLoad && (routeIndex < drive_status_pkg::TERM_IDX_W'(drive_status_pkg::NUM_TERMS))) begin
      route_next[routeIndex] = routeCode;
    end
  end

  // Selector registers; reset restores the dedicated terminal assignments
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < drive_status_pkg::NUM_TERMS; i++) begin
        route_reg[i] <= drive_status_pkg::SEL_NONE;
      end
      route_reg[drive_status_pkg::TERM_CHANGEOVER] <= drive_status_pkg::SEL_TRIP;
      route_reg[drive_status_pkg::TERM_FREQ_ONE]   <= drive_status_pkg::SEL_FREQ_ONE;
      route_reg[drive_status_pkg::TERM_AT_SPEED]   <= drive_status_pkg::SEL_AT_SPEED;
    end else begin
      for (int i = 0; i < drive_status_pkg::NUM_TERMS; i++) begin
        route_reg[i] <= route_next[i];
      end
    end
  end

  // Fault latches; a new trip beats a reset in the same cycle
  // The trip output itself clears as soon as the reset period starts
  // Shutoff only follows a trip that carries one of the listed causes
  always_comb begin
    tripAny        = tripRequest | stallTrip_reg;
    resetSeen_next = faultReset;
    tripOut_next   = tripOut_reg;
    heldTrip_next  = heldTrip_reg;
    shutoff_next   = shutoff_reg;
    if (faultReset) begin
      tripOut_next = 1'b0;
    end
    // Held trip and shutoff drop only when the reset period ends
    if (resetSeen_reg && !faultReset) begin
      heldTrip_next = 1'b0;
      shutoff_next  = 1'b0;
    end
    if (tripAny) begin
      tripOut_next  = 1'b1;
      heldTrip_next = 1'b1;
    end
    if (tripRequest && (|tripCause)) begin
      shutoff_next = 1'b1;
    end
  end

  // Fault latch registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tripOut_reg   <= 1'b0;
      heldTrip_reg  <= 1'b0;
      shutoff_reg   <= 1'b0;
      resetSeen_reg <= 1'b0;
    end else begin
      tripOut_reg   <= tripOut_next;
      heldTrip_reg  <= heldTrip_next;
      shutoff_reg   <= shutoff_next;
      resetSeen_reg <= resetSeen_next;
    end
  end

  // Compared frequency, motor speed and active first threshold
  // Open-loop modes measure no speed, so speed detects fall back to output frequency
  always_comb begin
    case (ctrlMode)
      drive_status_pkg::MODE_VF: begin
        compFreq   = outputFreq;
        motorSpeed = outputFreq;
      end
      drive_status_pkg::MODE_FLUX: begin
        compFreq   = preSlipFreq;
        motorSpeed = outputFreq;
      end
      drive_status_pkg::MODE_SENSORLESS: begin
        compFreq   = estimatedSpeed;
        motorSpeed = estimatedSpeed;
      end
      drive_status_pkg::MODE_VECTOR: begin
        compFreq   = feedbackSpeed;
        motorSpeed = feedbackSpeed;
      end
      default: begin
        compFreq   = outputFreq;
        motorSpeed = outputFreq;
      end
    endcase
    if (reverseRun && (thresholds.reverseFirstThr != drive_status_pkg::REV_SAME_AS_FIRST)) begin
      firstActive = thresholds.reverseFirstThr;
    end else begin
      firstActive = thresholds.firstThr;
    end
    freqDiff   = (compFreq >= commandFreq) ? compFreq - commandFreq : commandFreq - compFreq;
    // Tolerance above 100 percent is clamped rather than widening the band further
    bandScaled = 24'(commandFreq) *
                 24'((thresholds.tolerance > drive_status_pkg::TOL_MAX) ? drive_status_pkg::TOL_MAX
                                                                        : thresholds.tolerance);
    diffScaled = 24'(freqDiff) * drive_status_pkg::PERCENT_FULL;
    inhibit    = dcBraking | preExciting | startTuning;
  end

  // Flag evaluation, speed flags sampled once per update period
  // Inhibit acts at the tick only; a flag may stand up to one period into braking
  always_comb begin
    flags_next = flags_reg;
    if (updateTick) begin
      flags_next.atSpeed    = (diffScaled <= bandScaled) && !inhibit;
      flags_next.freqOne    = atOrAbove(outputFreq, firstActive) && !inhibit;
      flags_next.freqTwo    = atOrAbove(outputFreq, thresholds.secondThr) && !inhibit;
      flags_next.freqThree  = atOrAbove(outputFreq, thresholds.thirdThr) && !inhibit;
      flags_next.speedOne   = atOrAbove(motorSpeed, firstActive) && !inhibit;
      flags_next.speedTwo   = atOrAbove(motorSpeed, thresholds.secondThr) && !inhibit;
      flags_next.speedThree = atOrAbove(motorSpeed, thresholds.thirdThr) && !inhibit;
      flags_next.lowSpeed   = (compFreq < thresholds.lowThr) && !inhibit;
    end
    // Fault flags follow their latches directly so a trip on status is never delayed by the tick
    flags_next.trip     = tripOut_reg;
    flags_next.heldTrip = heldTrip_reg;
    flags_next.shutoff  = shutoff_reg;
  end

  // Flag registers; cleared in reset so no terminal shows a stale flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Stall detector counts every clock while the overload persists
  // Counting in clocks trades a wide counter for an exact hold time
  always_comb begin
    stallCond = ((ctrlMode == drive_status_pkg::MODE_SENSORLESS) || (ctrlMode == drive_status_pkg::MODE_VECTOR)) &&
                torqueLimiting && (compFreq <= thresholds.lowThr) &&
                (outputTorque > overloadTorqueLevel);
    stallTrip_next = 1'b0;
    if (!stallCond || tripOut_reg) begin
      stall_next = '0;
    end else if (stall_reg >= drive_status_pkg::STALL_W'(STALL_CYCLES)) begin
      stall_next     = '0;
      stallTrip_next = 1'b1;
    end else begin
      stall_next = stall_reg + 1'b1;
    end
  end

  // Stall counter and trip pulse registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stall_reg     <= '0;
      stallTrip_reg <= 1'b0;
    end else begin
      stall_reg     <= stall_next;
      stallTrip_reg <= stallTrip_next;
    end
  end

  // Terminal routing; all terminals change together on the tick
  // Terminals read the registered flags, so they lag the flags by one update period
  always_comb begin
    term_next = term_reg;
    if (updateTick) begin
      for (int i = 0; i < drive_status_pkg::NUM_TERMS; i++) begin
        term_next[i] = routeBit(route_reg[i], flags_reg);
      end
    end
  end

  // Terminal registers; all seven change on the same edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      term_reg <= '0;
    end else begin
      term_reg <= term_next;
    end
  end

  // Outputs straight from flip-flops
  assign status         = flags_reg;
  assign stallTripFault = stallTrip_reg;
  assign terminalOut    = term_reg;

endmodule // drive_status_outputs

// *** sim/relay_bank.sv ***
`timescale 1ns/10ps
// Relay bank behind the terminals; each contact follows its terminal one clock late
module relay_bank (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Terminals in, contacts out
  input  wire logic [6:0] terminalOut,
  output logic      [6:0] contactClosed
);
  logic [6:0] contact_reg;
  logic [6:0] contact_next;

  // Coil pulls in a clock late, so a one-clock glitch would still be seen
  always_comb begin
    contact_next = terminalOut;
  end

  // Contacts drop open while the drive is held in reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      contact_reg <= 7'h00;
    end else begin
      contact_reg <= contact_next;
    end
  end

  assign contactClosed = contact_reg;
endmodule // relay_bank

// *** sim/drive_status_outputs_chk.sv ***
`timescale 1ns/10ps
// Port-level watch on the status block
module drive_status_outputs_chk #(
  parameter int STALL_CYCLES = 20
) (
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         rst,
  // Inputs watched
  input wire drive_status_pkg::ctrl_mode_e ctrlMode,
  input wire logic                         dcBraking,
  input wire logic                         preExciting,
  input wire logic                         startTuning,
  input wire logic                         routeLoad,
  input wire logic                         tripRequest,
  input wire logic [10:0]                  tripCause,
  input wire logic                         faultReset,
  // Outputs watched
  input wire drive_status_pkg::status_s    status,
  input wire logic                         stallTripFault,
  input wire logic [6:0]                   terminalOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [6:0] inh_reg;
  logic [6:0] inh_next;
  logic       routed_reg;
  logic       routed_next;
  logic [7:0] spd;

  // Length of the current inhibit spell, and whether any route was reloaded
  always_comb begin
    inh_next = (dcBraking | preExciting | startTuning) ? inh_reg + 7'h01 : 7'h00;
    if ((inh_reg == 7'h7f) && (dcBraking | preExciting | startTuning)) begin
      inh_next = inh_reg; // Saturate so a long spell never wraps
    end
    routed_next = routed_reg | routeLoad;
  end

  // Helper registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inh_reg    <= 7'h00;
      routed_reg <= 1'b0;
    end else begin
      inh_reg    <= inh_next;
      routed_reg <= routed_next;
    end
  end

  assign spd = status[10:3];

  sequence s_trip_after;
    !stallTripFault ##1 status.trip;
  endsequence

  a_trip_sets_both: assert property (tripRequest |-> ##2 (status.trip && status.heldTrip))
    else $error("trip request missed a trip output");
  a_trip_clears: assert property (faultReset && !tripRequest && !stallTripFault |-> ##2 !status.trip)
    else $error("trip output survived fault reset");
  a_held_in_reset: assert property (faultReset && $past(faultReset) && status.heldTrip |=> status.heldTrip)
    else $error("held trip dropped during reset");
  a_shutoff_on_cause: assert property (tripRequest && (|tripCause) |-> ##2 status.shutoff)
    else $error("shutoff missing for listed cause");
  a_shutoff_only_cause: assert property (!(tripRequest && (|tripCause)) ##1 !status.shutoff |=> !status.shutoff)
    else $error("shutoff raised without listed cause");
  a_inhibit_flags: assert property (inh_reg >= 7'h34 |-> spd == 8'h00)
    else $error("speed flags on while inhibited");
  a_flags_per_tick: assert property ($changed(spd) |=> $stable(spd) [*8])
    else $error("speed flags moved between updates");
  a_stall_pulse: assert property (stallTripFault |=> s_trip_after)
    else $error("stall pulse not single or no trip");
  a_stall_mode: assert property (stallTripFault |-> $past(ctrlMode, 2) inside {drive_status_pkg::MODE_SENSORLESS,
    drive_status_pkg::MODE_VECTOR})
    else $error("stall trip in open loop");
  a_trip_default: assert property (!routed_reg && $changed(terminalOut[5]) |-> terminalOut[5] == $past(status.trip))
    else $error("changeover contact not following trip");
  a_freq_default: assert property (!routed_reg && $changed(terminalOut[4]) |-> terminalOut[4] == $past(status.freqOne))
    else $error("terminal 4 not following detect one");
endmodule // drive_status_outputs_chk

bind drive_status_outputs drive_status_outputs_chk #(.STALL_CYCLES(STALL_CYCLES)) chk (.ref_clk(ref_clk), .rst(rst),
  .ctrlMode(ctrlMode), .dcBraking(dcBraking), .preExciting(preExciting), .startTuning(startTuning),
  .routeLoad(routeLoad), .tripRequest(tripRequest), .tripCause(tripCause), .faultReset(faultReset),
  .status(status), .stallTripFault(stallTripFault), .terminalOut(terminalOut));

// *** sim/drive_status_outputs_tb.sv ***
`timescale 1ns/10ps
module drive_status_outputs_tb;
  // Stimulus, driven 2 ns after each rising edge
  logic                          ref_clk, rst, rev, dcb, pre, tun, tql, rLoad, tReq, fRst, stallFlt;
  drive_status_pkg::ctrl_mode_e  mode;
  drive_status_pkg::freq_t       cmdF, outF, preF, estF, fbF;
  logic [15:0]                   torque, tLevel;
  drive_status_pkg::thresholds_s thr, thrDef;
  logic [2:0]                    rIdx;
  drive_status_pkg::sel_t        rCode;
  logic [10:0]                   cause;
  drive_status_pkg::status_s     st, expS;
  logic [6:0]                    term, contact;
  int                            fails, compares, k;
  drive_status_pkg::sel_t        codes[11] = '{8'h04, 8'h05, 8'h06, 8'h29, 8'h2a, 8'h2b, 8'h22, 8'h5b, 8'h5e,
                                               drive_status_pkg::SEL_TRIP, drive_status_pkg::SEL_AT_SPEED};
  int                            bitOf[11] = '{9, 8, 7, 6, 5, 4, 3, 0, 1, 2, 10};

  drive_status_outputs #(.STALL_CYCLES(20)) DUT (.ref_clk(ref_clk), .rst(rst), .ctrlMode(mode),
    .commandFreq(cmdF), .outputFreq(outF), .preSlipFreq(preF), .estimatedSpeed(estF), .feedbackSpeed(fbF),
    .reverseRun(rev), .dcBraking(dcb), .preExciting(pre), .startTuning(tun), .outputTorque(torque),
    .torqueLimiting(tql), .thresholds(thr), .overloadTorqueLevel(tLevel), .routeLoad(rLoad), .routeIndex(rIdx),
    .routeCode(rCode), .tripRequest(tReq), .tripCause(cause), .faultReset(fRst), .status(st),
    .stallTripFault(stallFlt), .terminalOut(term));
  relay_bank REL (.ref_clk(ref_clk), .rst(rst), .terminalOut(term), .contactClosed(contact));

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected speed flags; fault bits are left at zero for the caller
  function automatic drive_status_pkg::status_s model();
    drive_status_pkg::status_s s;
    drive_status_pkg::freq_t   comp, spd, first;
    logic [31:0]               diff;
    s = '0;
    spd = (mode == drive_status_pkg::MODE_SENSORLESS) ? estF : (mode == drive_status_pkg::MODE_VECTOR) ? fbF : outF;
    comp = (mode == drive_status_pkg::MODE_FLUX) ? preF : spd;
    first = (rev && thr.reverseFirstThr != drive_status_pkg::REV_SAME_AS_FIRST) ? thr.reverseFirstThr : thr.firstThr;
    diff = (comp > cmdF) ? 32'(comp - cmdF) : 32'(cmdF - comp);
    s.atSpeed = diff * 100 <= 32'(cmdF) * 32'(thr.tolerance);
    s.freqOne = outF >= first;
    s.freqTwo = outF >= thr.secondThr;
    s.freqThree = outF >= thr.thirdThr;
    s.speedOne = spd >= first;
    s.speedTwo = spd >= thr.secondThr;
    s.speedThree = spd >= thr.thirdThr;
    s.lowSpeed = comp < thr.lowThr;
    return (dcb | pre | tun) ? '0 : s;
  endfunction

  // Expected terminal level; unknown codes give an idle low terminal
  function automatic logic route(input drive_status_pkg::sel_t c);
    logic neg;
    neg = (c >= 8'h64) && (c != 8'hff);
    route = 1'b0;
    for (int j = 0; j < 11; j++) begin
      if ((neg ? c - 8'h64 : c) == codes[j]) begin
        route = expS[bitOf[j]] ^ neg;
      end
    end
  endfunction

  task automatic trip(input logic [10:0] c);
    cause = c;
    tReq = 1'b1;
    step(1);
    tReq = 1'b0;
    step(1);
  endtask

  task automatic clearFault(input logic sh);
    fRst = 1'b1;
    step(10);
    check(16'(st[2:0]), 16'({2'b01, sh}), "held in reset");
    fRst = 1'b0;
    step(3);
    check(16'(st[2:0]), 16'h0000, "cleared");
  endtask

  task automatic defaults;
    mode = drive_status_pkg::MODE_VF;
    {rev, dcb, pre, tun, tql} = '0;
    thr = thrDef;
    cmdF = 16'h0258;
    outF = 16'h021c; // Exactly 10 percent under the command
  endtask

  initial begin
    {ref_clk, rev, dcb, pre, tun, tql, rLoad, tReq, fRst, rIdx, rCode, cause} = '0;
    {cmdF, outF, preF, estF, fbF, torque, tLevel} = '0;
    rst = 1'b1;
    mode = drive_status_pkg::MODE_VF;
    thrDef = {drive_status_pkg::TOL_DEF, drive_status_pkg::FIRST_THR_DEF, drive_status_pkg::REV_SAME_AS_FIRST,
              drive_status_pkg::SECOND_THR_DEF, drive_status_pkg::THIRD_THR_DEF, drive_status_pkg::LOW_THR_DEF};
    thr = thrDef;
    fails = 0;
    compares = 0;
    k = $urandom(4503);
    step(12);
    rst = 1'b0;
    // Defaults after reset and a trip with no listed cause
    defaults();
    step(150);
    expS = model();
    check(16'(st[10:3]), 16'(expS[10:3]), "defaults");
    check(16'({term[4], term[1]}), 16'({expS.freqOne, expS.atSpeed}), "dedicated");
    check(16'({term[6], term[3:2]}), 16'h0000, "idle terms");
    trip(11'h000);
    check(16'(st[2:0]), 16'h0006, "trip no cause");
    step(100);
    check(16'(term[5]), 16'h0001, "changeover");
    clearFault(1'b0);
    $display("test defaults done");
    // Every listed cause opens the contactor
    for (int j = 0; j < 11; j++) begin
      trip(11'(1 << j));
      check(16'(st[2:0]), 16'h0007, "cause");
      clearFault(1'b1);
    end
    $display("test causes done");
    // Random comparisons with boundary and inhibit cases mixed in
    for (int i = 0; i < 40; i++) begin
      mode = drive_status_pkg::ctrl_mode_e'($urandom_range(3));
      {cmdF, outF, preF, estF, fbF} = {16'($urandom_range(4000)), 16'($urandom_range(4000)),
        16'($urandom_range(4000)), 16'($urandom_range(4000)), 16'($urandom_range(4000))};
      thr = {7'($urandom_range(100)), 16'($urandom_range(4000)), 16'($urandom_range(4000)),
        16'($urandom_range(4000)), 16'($urandom_range(4000)), 16'($urandom_range(4000))};
      rev = 1'($urandom_range(1));
      thr.reverseFirstThr = (i % 2 == 0) ? drive_status_pkg::REV_SAME_AS_FIRST : thr.reverseFirstThr;
      outF = (i % 4 == 1) ? (rev ? thr.reverseFirstThr : thr.firstThr) : outF;
      preF = (i % 3 == 0) ? cmdF : preF;
      {dcb, pre, tun} = (i % 5 == 4) ? 3'(3'h1 << $urandom_range(2)) : 3'h0;
      step(100);
      expS = model();
      check(16'(st[10:3]), 16'(expS[10:3]), "flags");
    end
    $display("test random done");
    // Every selector code, cycled across terminals 0 to 6, with all faults raised
    defaults();
    trip(11'h001);
    expS = model();
    expS[2:0] = 3'b111;
    for (int j = 0; j < 24; j++) begin
      rCode = (j < 11) ? codes[j] : (j < 22) ? codes[j - 11] + 8'h64 : (j == 22) ? 8'h07 : 8'hff;
      rIdx = 3'(j % 7);
      rLoad = 1'b1;
      step(1);
      rLoad = 1'b0;
      step(100);
      check(16'(term[rIdx]), 16'(route(rCode)), "route");
      check(16'(contact[rIdx]), 16'(route(rCode)), "relay");
    end
    clearFault(1'b1);
    $display("test routes done");
    // Stall at low speed trips only in closed loop
    mode = drive_status_pkg::MODE_SENSORLESS;
    {estF, torque, tLevel, tql} = {16'h000a, 16'h0100, 16'h0080, 1'b1};
    k = 0;
    while (stallFlt !== 1'b1 && k < 60) begin
      step(1);
      k++;
    end
    if (k == 60) begin
      fails++;
      test_done();
    end
    step(2);
    check(16'(st.trip), 16'h0001, "stall trip");
    tql = 1'b0;
    clearFault(1'b0);
    mode = drive_status_pkg::MODE_VF;
    {outF, tql} = {16'h000a, 1'b1};
    step(60);
    check(16'(st.trip), 16'h0000, "open loop stall");
    $display("test stall done");
    test_done();
  end
endmodule // drive_status_outputs_tb
